// ==== tcjs_consts.svh ====
// Constants for the timecode jam sync controller: register map, fields, reset values, timing.
// Assumes a 250 MHz system clock and a word-addressed Avalon-MM slave port.
`ifndef TCJS_CONSTS_SVH
`define TCJS_CONSTS_SVH

// Register word indices (byte address is four times the index)
`define TCJS_REG_CTRL 3'h0
`define TCJS_REG_POLICY 3'h1
`define TCJS_REG_START_TIME 3'h2
`define TCJS_REG_START_DATE 3'h3
`define TCJS_REG_INTERVAL 3'h4
`define TCJS_REG_STATUS 3'h5

// Control register bits
`define TCJS_CTRL_SEL_BIT 0
`define TCJS_CTRL_NOW_BIT 1
`define TCJS_CTRL_SCHED_EN_BIT 2
`define TCJS_CTRL_CF_LOCK_BIT 3

// Start time fields (binary hours, minutes, seconds)
`define TCJS_TIME_HH_LSB 16
`define TCJS_TIME_MM_LSB 8
`define TCJS_TIME_SS_LSB 0
// Start date fields (binary year, month, day)
`define TCJS_DATE_YEAR_LSB 16
`define TCJS_DATE_MONTH_LSB 8
`define TCJS_DATE_DAY_LSB 0
// Interval fields
`define TCJS_INTV_COUNT_LSB 0
`define TCJS_INTV_UNIT_BIT 16

// Status fields
`define TCJS_STAT_RUN_LSB 0
`define TCJS_STAT_BUSY_LSB 2
`define TCJS_STAT_ARMED_BIT 4
`define TCJS_STAT_REPEAT_BIT 5
`define TCJS_STAT_COUNT_LSB 16

// Reset values
`define TCJS_RST_INTV_COUNT 16'h0001
`define TCJS_RST_INTV_UNIT 1'b0
`define TCJS_RST_POLICY 1'b0

// Time base
`define TCJS_SECS_PER_HOUR 17'h00e10
`define TCJS_SECS_PER_DAY 17'h15180
`define TCJS_SECS_PER_MIN 17'h0003c
`define TCJS_FPS_NTSC 5'h1e
`define TCJS_FPS_25 5'h19
`define TCJS_FPS_30 5'h1e
`define TCJS_FPS_24 5'h18

// Restart gap: stream held silent this long before it restarts
`define TCJS_CLK_PERIOD_NS 4
`define TCJS_STOP_TIME_NS 1000
`define TCJS_STOP_CYCLES ((`TCJS_STOP_TIME_NS + `TCJS_CLK_PERIOD_NS - 1) / `TCJS_CLK_PERIOD_NS)

`endif

// ==== tcjs_pkg.sv ====
// Types shared by the timecode jam sync controller and its scheduler.
// Assumes nothing beyond a SystemVerilog compiler.
package tcjs_pkg;

	typedef enum logic [2:0] {
		TCJS_FMT_NT_NDROP,
		TCJS_FMT_NT_DROP,
		TCJS_FMT_25,
		TCJS_FMT_30_NDROP,
		TCJS_FMT_24_NDROP
	} tcjs_fmt_t;

	typedef struct packed {
		logic [4:0] hh;
		logic [5:0] mm;
		logic [5:0] ss;
	} tcjs_tod_t;

	typedef struct packed {
		logic [15:0] year;
		logic [3:0] month;
		logic [4:0] day;
	} tcjs_date_t;

	// Date first so a packed compare orders stamps in time
	typedef struct packed {
		tcjs_date_t date;
		tcjs_tod_t tod;
	} tcjs_stamp_t;

	typedef struct packed {
		logic unit_hour;
		logic [15:0] count;
	} tcjs_interval_t;

	typedef struct packed {
		logic [1:0] fmt_chg;
		logic [1:0] phase_chg;
		logic src_update;
		logic tz_change;
	} tcjs_disc_t;

	typedef struct packed {
		logic run;
		logic reload;
		tcjs_date_t date;
		logic [21:0] frame_idx;
	} tcjs_ltc_t;

	typedef enum {
		TCJS_JS_IDLE,
		TCJS_JS_STOP,
		TCJS_JS_WAIT_CF
	} tcjs_jam_state_t;

endpackage

// ==== tcjs_sched.sv ====
// Scheduled jam sync timer: first fire at the start stamp, then every interval.
// Assumes now and sec_tick come from the internal time base on the same clock.
`include "tcjs_consts.svh"

module tcjs_sched (
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire tcjs_pkg::tcjs_stamp_t start,
	input wire tcjs_pkg::tcjs_interval_t interval,
	input wire tcjs_pkg::tcjs_stamp_t now,
	input wire logic sec_tick,
	output logic fire,
	output logic armed,
	output logic repeating
);
	import tcjs_pkg::*;

	logic en_q;
	logic armed_q;
	logic repeat_q;
	logic fire_q;
	logic [33:0] cnt_q;
	logic [33:0] intv_secs;
	logic first_hit;
	logic zero_intv;
	logic rep_hit;

	assign zero_intv = (interval.count == 16'h0000);
	assign intv_secs = 34'(interval.count * (interval.unit_hour ? `TCJS_SECS_PER_HOUR
		: `TCJS_SECS_PER_DAY));
	assign first_hit = enable && armed_q && (now >= start);
	// Zero interval keeps trying once a second rather than every clock
	assign rep_hit = enable && repeat_q && sec_tick && (zero_intv || cnt_q <= 34'h1);

	always_ff @(posedge clk) begin
		if (rst) begin
			en_q <= 1'b0;
		end else begin
			en_q <= enable;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !enable) begin
			armed_q <= 1'b0;
		end else if (!en_q) begin
			armed_q <= 1'b1;
		end else if (first_hit) begin
			armed_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !enable) begin
			repeat_q <= 1'b0;
			cnt_q <= 34'h0;
		end else if (first_hit || rep_hit) begin
			repeat_q <= 1'b1;
			cnt_q <= intv_secs;
		end else if (repeat_q && sec_tick) begin
			cnt_q <= cnt_q - 34'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			fire_q <= 1'b0;
		end else begin
			fire_q <= first_hit || rep_hit;
		end
	end

	assign fire = fire_q;
	assign armed = armed_q;
	assign repeating = repeat_q;
endmodule

// ==== tcjs_top.sv ====
// Timecode jam sync controller for two LTC outputs with an Avalon-MM register port.
// Assumes time base, frame ticks, colour-frame pulses and discontinuity events
// arrive from logic on the same clock, so none of them is synchronised here.
`include "tcjs_consts.svh"

// Function
// - Default schedule jams output once per day
// - Immediate trigger jams the selected output
// - Immediate trigger ignored while schedule enabled
// - Hold start time and date for schedule
// - Interval is count of days or hours
// - Zero interval retries jam sync continuously, here once per sec_tick
// - Scheduled jams only while enabled, then repeat
// - Listed events count as time-base discontinuities
// - Restart policy stops stream, restarts updated
// - Payload-only policy keeps stream, updates payload
// - Payload-only residual error up to frames
// - Colour-frame lock keeps colour-frame relationship
// - Payload-only lock keeps relation, no alignment
// - Format change under payload-only misaligns, expected
// - Policy stored per output, written via selector
module tcjs_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire tcjs_pkg::tcjs_stamp_t tb_now,
	input wire logic [4:0] tb_frame,
	input wire logic tb_sec_tick,
	input wire tcjs_pkg::tcjs_fmt_t [1:0] output_frame_format,
	input wire logic [1:0][21:0] phase_ofs_frames,
	input wire logic [21:0] tz_ofs_frames,
	input wire logic [1:0] frame_tick,
	input wire logic [1:0] cf_sync,
	input wire tcjs_pkg::tcjs_disc_t disc_event,
	output tcjs_pkg::tcjs_ltc_t [1:0] ltc_out
);
	import tcjs_pkg::*;

	logic ack_q;
	logic do_wr;
	logic do_rd;
	logic [31:0] wmask;
	logic [31:0] readdata_q;
	logic [31:0] rd_mux;
	logic output_selector_q;
	logic scheduled_resync_enable_q;
	logic colour_frame_lock_q;
	logic [1:0] discontinuity_policy_q;
	tcjs_stamp_t resync_start_q;
	tcjs_interval_t resync_interval_q;
	logic now_pulse_q;
	logic sched_fire;
	logic sched_armed;
	logic sched_repeat;
	logic [31:0] ctrl_new;
	logic [1:0] run_v;
	logic [1:0] busy_v;
	logic [1:0][7:0] jam_count;

	// Avalon slave: one wait cycle, read data registered before waitrequest drops
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign do_wr = avs_write && ack_q;
	assign do_rd = avs_read && !ack_q;

	always_comb begin
		wmask = 32'h0;
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read || avs_write) && !ack_q;
		end
	end

	always_comb begin
		rd_mux = 32'h0;
		unique case (avs_address)
			`TCJS_REG_CTRL: begin
				rd_mux[`TCJS_CTRL_SEL_BIT] = output_selector_q;
				rd_mux[`TCJS_CTRL_SCHED_EN_BIT] = scheduled_resync_enable_q;
				rd_mux[`TCJS_CTRL_CF_LOCK_BIT] = colour_frame_lock_q;
			end
			`TCJS_REG_POLICY: begin
				rd_mux[0] = discontinuity_policy_q[output_selector_q];
			end
			`TCJS_REG_START_TIME: begin
				rd_mux[`TCJS_TIME_HH_LSB +: 5] = resync_start_q.tod.hh;
				rd_mux[`TCJS_TIME_MM_LSB +: 6] = resync_start_q.tod.mm;
				rd_mux[`TCJS_TIME_SS_LSB +: 6] = resync_start_q.tod.ss;
			end
			`TCJS_REG_START_DATE: begin
				rd_mux[`TCJS_DATE_YEAR_LSB +: 16] = resync_start_q.date.year;
				rd_mux[`TCJS_DATE_MONTH_LSB +: 4] = resync_start_q.date.month;
				rd_mux[`TCJS_DATE_DAY_LSB +: 5] = resync_start_q.date.day;
			end
			`TCJS_REG_INTERVAL: begin
				rd_mux[`TCJS_INTV_COUNT_LSB +: 16] = resync_interval_q.count;
				rd_mux[`TCJS_INTV_UNIT_BIT] = resync_interval_q.unit_hour;
			end
			`TCJS_REG_STATUS: begin
				rd_mux[`TCJS_STAT_RUN_LSB +: 2] = run_v;
				rd_mux[`TCJS_STAT_BUSY_LSB +: 2] = busy_v;
				rd_mux[`TCJS_STAT_ARMED_BIT] = sched_armed;
				rd_mux[`TCJS_STAT_REPEAT_BIT] = sched_repeat;
				rd_mux[`TCJS_STAT_COUNT_LSB +: 8] = jam_count[output_selector_q];
			end
			default: begin
				rd_mux = 32'h0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			readdata_q <= 32'h0;
		end else if (do_rd) begin
			readdata_q <= rd_mux;
		end
	end
	assign avs_readdata = readdata_q;

	assign ctrl_new = avs_writedata & wmask;

	always_ff @(posedge clk) begin
		if (rst) begin
			output_selector_q <= 1'b0;
			scheduled_resync_enable_q <= 1'b0;
			colour_frame_lock_q <= 1'b0;
		end else if (do_wr && avs_address == `TCJS_REG_CTRL && avs_byteenable[0]) begin
			output_selector_q <= ctrl_new[`TCJS_CTRL_SEL_BIT];
			scheduled_resync_enable_q <= ctrl_new[`TCJS_CTRL_SCHED_EN_BIT];
			colour_frame_lock_q <= ctrl_new[`TCJS_CTRL_CF_LOCK_BIT];
		end
	end

	// Trigger bit is write-one, self-clearing; enable in the same write already counts
	always_ff @(posedge clk) begin
		if (rst) begin
			now_pulse_q <= 1'b0;
		end else begin
			now_pulse_q <= do_wr && avs_address == `TCJS_REG_CTRL && avs_byteenable[0]
				&& ctrl_new[`TCJS_CTRL_NOW_BIT] && !ctrl_new[`TCJS_CTRL_SCHED_EN_BIT]
				&& !scheduled_resync_enable_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			discontinuity_policy_q <= {2{`TCJS_RST_POLICY}};
		end else if (do_wr && avs_address == `TCJS_REG_POLICY && avs_byteenable[0]) begin
			discontinuity_policy_q[output_selector_q] <= avs_writedata[0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			resync_start_q <= '0;
		end else if (do_wr && avs_address == `TCJS_REG_START_TIME) begin
			if (avs_byteenable[2]) begin
				resync_start_q.tod.hh <= avs_writedata[`TCJS_TIME_HH_LSB +: 5];
			end
			if (avs_byteenable[1]) begin
				resync_start_q.tod.mm <= avs_writedata[`TCJS_TIME_MM_LSB +: 6];
			end
			if (avs_byteenable[0]) begin
				resync_start_q.tod.ss <= avs_writedata[`TCJS_TIME_SS_LSB +: 6];
			end
		end else if (do_wr && avs_address == `TCJS_REG_START_DATE) begin
			if (avs_byteenable[3] && avs_byteenable[2]) begin
				resync_start_q.date.year <= avs_writedata[`TCJS_DATE_YEAR_LSB +: 16];
			end
			if (avs_byteenable[1]) begin
				resync_start_q.date.month <= avs_writedata[`TCJS_DATE_MONTH_LSB +: 4];
			end
			if (avs_byteenable[0]) begin
				resync_start_q.date.day <= avs_writedata[`TCJS_DATE_DAY_LSB +: 5];
			end
		end
	end

	// Once a day by default keeps 29.97 fps drift to a fraction of a frame
	always_ff @(posedge clk) begin
		if (rst) begin
			resync_interval_q.count <= `TCJS_RST_INTV_COUNT;
			resync_interval_q.unit_hour <= `TCJS_RST_INTV_UNIT;
		end else if (do_wr && avs_address == `TCJS_REG_INTERVAL) begin
			if (avs_byteenable[1] && avs_byteenable[0]) begin
				resync_interval_q.count <= avs_writedata[`TCJS_INTV_COUNT_LSB +: 16];
			end
			if (avs_byteenable[2]) begin
				resync_interval_q.unit_hour <= avs_writedata[`TCJS_INTV_UNIT_BIT];
			end
		end
	end

	tcjs_sched u_sched (
		.clk(clk),
		.rst(rst),
		.enable(scheduled_resync_enable_q),
		.start(resync_start_q),
		.interval(resync_interval_q),
		.now(tb_now),
		.sec_tick(tb_sec_tick),
		.fire(sched_fire),
		.armed(sched_armed),
		.repeating(sched_repeat)
	);

	function automatic logic [4:0] fps_of(input tcjs_fmt_t f);
		unique case (f)
			TCJS_FMT_NT_NDROP, TCJS_FMT_NT_DROP: fps_of = `TCJS_FPS_NTSC;
			TCJS_FMT_25: fps_of = `TCJS_FPS_25;
			TCJS_FMT_30_NDROP: fps_of = `TCJS_FPS_30;
			TCJS_FMT_24_NDROP: fps_of = `TCJS_FPS_24;
			default: fps_of = `TCJS_FPS_30;
		endcase
	endfunction

	logic [16:0] tb_sod;
	assign tb_sod = 17'(tb_now.tod.hh * `TCJS_SECS_PER_HOUR)
		+ 17'(tb_now.tod.mm * `TCJS_SECS_PER_MIN) + 17'(tb_now.tod.ss);

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_out
			tcjs_jam_state_t state_q;
			logic [7:0] stop_cnt_q;
			logic [7:0] jams_q;
			logic run_q;
			logic reload_q;
			tcjs_date_t date_q;
			logic [21:0] frame_q;
			logic [4:0] fps;
			logic [21:0] fpd;
			logic [23:0] sum;
			logic [21:0] target;
			logic jam_req;
			logic disc;
			logic payload_only;
			logic do_reload;

			assign fps = fps_of(output_frame_format[gi]);
			assign fpd = 22'(fps * `TCJS_SECS_PER_DAY);
			// Time base plus phasing and zone offsets, folded into one day
			assign sum = 24'(tb_sod * fps) + 24'(tb_frame) + 24'(phase_ofs_frames[gi])
				+ 24'(tz_ofs_frames);
			always_comb begin
				if (sum >= {fpd, 1'b0}) begin
					target = 22'(sum - {1'b0, fpd, 1'b0});
				end else if (sum >= 24'(fpd)) begin
					target = 22'(sum - 24'(fpd));
				end else begin
					target = sum[21:0];
				end
			end

			assign jam_req = (now_pulse_q || sched_fire) && (output_selector_q == gi);
			assign disc = jam_req || disc_event.fmt_chg[gi] || disc_event.phase_chg[gi]
				|| disc_event.src_update || disc_event.tz_change;
			assign payload_only = discontinuity_policy_q[gi];
			// Payload-only never realigns to colour frame or to the new format phase
			assign do_reload = (disc && payload_only)
				|| (state_q == TCJS_JS_STOP && stop_cnt_q == 8'h0 && !disc
					&& !colour_frame_lock_q)
				|| (state_q == TCJS_JS_WAIT_CF && cf_sync[gi] && !disc);

			always_ff @(posedge clk) begin
				if (rst) begin
					state_q <= TCJS_JS_IDLE;
					stop_cnt_q <= 8'h0;
				end else if (disc && !payload_only) begin
					state_q <= TCJS_JS_STOP;
					stop_cnt_q <= 8'(`TCJS_STOP_CYCLES - 1);
				end else begin
					unique case (state_q)
						TCJS_JS_IDLE: begin
						end
						TCJS_JS_STOP: begin
							if (stop_cnt_q != 8'h0) begin
								stop_cnt_q <= stop_cnt_q - 8'h1;
							end else if (colour_frame_lock_q) begin
								state_q <= TCJS_JS_WAIT_CF;
							end else begin
								state_q <= TCJS_JS_IDLE;
							end
						end
						TCJS_JS_WAIT_CF: begin
							if (cf_sync[gi]) begin
								state_q <= TCJS_JS_IDLE;
							end
						end
					endcase
				end
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					run_q <= 1'b1;
				end else if (disc && !payload_only) begin
					run_q <= 1'b0;
				end else if (do_reload) begin
					run_q <= 1'b1;
				end
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					frame_q <= 22'h0;
					date_q <= '0;
					reload_q <= 1'b0;
				end else begin
					reload_q <= do_reload;
					if (do_reload) begin
						frame_q <= target;
						date_q <= tb_now.date;
					end else if (run_q && frame_tick[gi]) begin
						frame_q <= (frame_q + 22'h1 >= fpd) ? 22'h0 : frame_q + 22'h1;
					end
				end
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					jams_q <= 8'h0;
				end else if (jam_req) begin
					jams_q <= jams_q + 8'h1;
				end
			end

			assign ltc_out[gi].run = run_q;
			assign ltc_out[gi].reload = reload_q;
			assign ltc_out[gi].date = date_q;
			assign ltc_out[gi].frame_idx = frame_q;
			assign run_v[gi] = run_q;
			assign busy_v[gi] = (state_q != TCJS_JS_IDLE);
			assign jam_count[gi] = jams_q;
		end
	endgenerate
endmodule

// ==== tcjs_top_properties.sv ====
// Checker for the jam sync controller, watching the top ports only.
// Assumes control words are written with all byte lanes enabled.
`include "tcjs_consts.svh"
module tcjs_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [1:0] cf_sync,
	input wire tcjs_pkg::tcjs_disc_t disc_event,
	input wire tcjs_pkg::tcjs_ltc_t [1:0] ltc_out
);
	import tcjs_pkg::*;
	logic sel_q, sched_q, cf_q, wr_ok, rd_ok, trig;
	logic [1:0] pol_q;
	logic [8:0] low_q;
	assign wr_ok = avs_write && !avs_waitrequest;
	assign rd_ok = avs_read && !avs_waitrequest;
	assign trig = wr_ok && avs_address == `TCJS_REG_CTRL && avs_writedata[1] && !avs_writedata[2]
		&& !sched_q;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	always_ff @(posedge clk) begin
		if (rst) begin
			sel_q <= 1'b0;
			sched_q <= 1'b0;
			cf_q <= 1'b0;
		end else if (wr_ok && avs_address == `TCJS_REG_CTRL) begin
			sel_q <= avs_writedata[0];
			sched_q <= avs_writedata[2];
			cf_q <= avs_writedata[3];
		end
	end
	// Mirror of the per-output policy, steered by the selector
	always_ff @(posedge clk) begin
		if (rst) begin
			pol_q <= 2'h0;
		end else if (wr_ok && avs_address == `TCJS_REG_POLICY) begin
			pol_q[sel_q] <= avs_writedata[0];
		end
	end
	// Saturates so a long colour-frame wait cannot wrap
	always_ff @(posedge clk) begin
		if (rst || ltc_out[0].run) begin
			low_q <= 9'h0;
		end else if (low_q != 9'h1ff) begin
			low_q <= low_q + 9'h1;
		end
	end
	wait_one_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("waitrequest not low one cycle after request");
	idle_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest high without request");
	trig0_jam_a: assert property (trig && !avs_writedata[0] |-> ##[1:4]
		(pol_q[0] ? ltc_out[0].reload : !ltc_out[0].run)) else $error("output 0 missed jam");
	trig1_jam_a: assert property (trig && avs_writedata[0] |-> ##[1:4]
		(pol_q[1] ? ltc_out[1].reload : !ltc_out[1].run)) else $error("output 1 missed jam");
	stop_len_a: assert property ($rose(ltc_out[0].run) |-> low_q >= `TCJS_STOP_CYCLES - 1)
		else $error("stream restarted too early");
	rise_reload_a: assert property ($rose(ltc_out[0].run) |-> ##[0:1] ltc_out[0].reload)
		else $error("restart without payload reload");
	reload_pulse_a: assert property (ltc_out[1].reload |=> !ltc_out[1].reload)
		else $error("reload longer than one cycle");
	payload_run_a: assert property (pol_q[1] |-> !$fell(ltc_out[1].run))
		else $error("payload-only output stopped");
	cf_wait_a: assert property (cf_q && $rose(ltc_out[0].run) |->
		$past(cf_sync[0]) || $past(cf_sync[0], 2)) else $error("restart off colour frame");
	fmt_disc_a: assert property (disc_event.fmt_chg[0] && !pol_q[0] |-> ##[1:4] !ltc_out[0].run)
		else $error("format change did not stop stream");
	src_disc_a: assert property (disc_event.src_update && pol_q[1] |-> ##[1:4] ltc_out[1].reload)
		else $error("source update did not reload");
	pol_read_a: assert property (rd_ok && avs_address == `TCJS_REG_POLICY |->
		avs_readdata[0] == pol_q[sel_q]) else $error("policy readback wrong");
	cover property (trig && !avs_writedata[0]);
	cover property ($rose(ltc_out[0].run) && cf_q);
	cover property (ltc_out[1].reload && pol_q[1]);
endmodule

bind tcjs_top tcjs_chk tcjs_chk_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cf_sync(cf_sync),
	.disc_event(disc_event), .ltc_out(ltc_out));

// ==== tcjs_ltc_rx.sv ====
// Receiving end of one LTC output: logs reloads, stream stops and payloads.
// Assumes the stream struct is sampled on the controller clock.
module tcjs_ltc_rx (
	input wire logic clk,
	input wire logic rst,
	input wire tcjs_pkg::tcjs_ltc_t ltc,
	output int reloads,
	output int stops,
	output int gap,
	output logic [21:0] frame,
	output tcjs_pkg::tcjs_date_t date
);
	import tcjs_pkg::*;
	int low_n;
	always @(posedge clk) begin
		if (rst) begin
			reloads <= 0;
			stops <= 0;
			gap <= 0;
			low_n <= 0;
			frame <= 22'h0;
			date <= '0;
		end else begin
			if (!ltc.run) begin
				low_n <= low_n + 1;
				if (low_n == 0) begin
					stops <= stops + 1;
				end
			end else if (low_n != 0) begin
				gap <= low_n;
				low_n <= 0;
			end
			if (ltc.reload) begin
				reloads <= reloads + 1;
				frame <= ltc.frame_idx;
				date <= ltc.date;
			end
		end
	end
endmodule

// ==== test_timecode_jam_sync_control.sv ====
// Self-checking bench for the jam sync controller and two LTC receivers.
// Assumes one 250 MHz clock and a time base held still by the bench except for one step to 01:02:04 in the schedule test.
`include "tcjs_consts.svh"
module test_timecode_jam_sync_control;
	timeunit 1ns;
	timeprecision 1ps;
	import tcjs_pkg::*;
	logic clk, rst, avs_read, avs_write, avs_waitrequest, tb_sec_tick;
	logic [2:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic [4:0] tb_frame;
	logic [1:0] frame_tick, cf_sync;
	logic [1:0][21:0] phase_ofs_frames;
	logic [21:0] tz_ofs_frames;
	tcjs_stamp_t tb_now;
	tcjs_fmt_t [1:0] output_frame_format;
	tcjs_disc_t disc_event;
	tcjs_ltc_t [1:0] ltc_out;
	int errors, comparisons, p, s;
	int reloads [2], stops [2], gap [2];
	logic [21:0] rx_frame [2];
	tcjs_date_t rx_date [2];
	tcjs_top tcjs_top_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .tb_now(tb_now), .tb_frame(tb_frame),
		.tb_sec_tick(tb_sec_tick), .output_frame_format(output_frame_format),
		.phase_ofs_frames(phase_ofs_frames), .tz_ofs_frames(tz_ofs_frames),
		.frame_tick(frame_tick), .cf_sync(cf_sync), .disc_event(disc_event), .ltc_out(ltc_out));
	for (genvar g = 0; g < 2; g++) begin : rx
		tcjs_ltc_rx tcjs_ltc_rx_inst (.clk(clk), .rst(rst), .ltc(ltc_out[g]),
			.reloads(reloads[g]), .stops(stops[g]), .gap(gap[g]), .frame(rx_frame[g]),
			.date(rx_date[g]));
	end
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Samples right after each rising edge, before that edge's updates land
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		chk("bus answer", 32'h0, {31'h0, avs_waitrequest});
	endtask
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input string what, input logic [2:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(what, exp, q);
	endtask
	task automatic wait_rl(input int o, input int prev, input int lim);
		int n;
		n = 0;
		while (reloads[o] == prev && n < lim) begin
			@(posedge clk);
			n++;
		end
		repeat (2) @(posedge clk);
		chk("reload count", prev + 1, reloads[o]);
	endtask
	task automatic idle(input int o, input int prev);
		repeat (300) @(posedge clk);
		chk("no reload", prev, reloads[o]);
	endtask
	task automatic disc(input tcjs_disc_t e);
		@(posedge clk);
		disc_event <= e;
		@(posedge clk);
		disc_event <= '0;
	endtask
	// Time base is 01:02:03, frame 5, zone offset 100 frames
	function automatic logic [31:0] exp_frame(input logic [31:0] ph);
		return (32'he8b * `TCJS_FPS_NTSC + 32'h69 + ph) % (`TCJS_SECS_PER_DAY * `TCJS_FPS_NTSC);
	endfunction
	task automatic t_reset;
		rd("ctrl", `TCJS_REG_CTRL, 32'h0);
		rd("policy", `TCJS_REG_POLICY, 32'h0);
		rd("interval", `TCJS_REG_INTERVAL, 32'h1);
		rd("status", `TCJS_REG_STATUS, 32'h3);
		wr(3'h7, 32'hffffffff);
		rd("unmapped", 3'h7, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_restart;
		p = reloads[0];
		wr(`TCJS_REG_CTRL, 32'h2);
		wait_rl(0, p, 400);
		chk("stop gap", 32'h1, {31'h0, gap[0] >= `TCJS_STOP_CYCLES});
		chk("frame", exp_frame(32'h7), {10'h0, rx_frame[0]});
		chk("date", {7'h0, tb_now.date}, {7'h0, rx_date[0]});
		frame_tick <= 2'h1;
		@(posedge clk);
		frame_tick <= 2'h0;
		@(negedge clk);
		chk("advance", exp_frame(32'h7) + 1, {10'h0, ltc_out[0].frame_idx});
		$display("test restart done");
	endtask
	task automatic t_payload;
		wr(`TCJS_REG_CTRL, 32'h1);
		wr(`TCJS_REG_POLICY, 32'h1);
		rd("policy sel1", `TCJS_REG_POLICY, 32'h1);
		wr(`TCJS_REG_CTRL, 32'h0);
		rd("policy sel0", `TCJS_REG_POLICY, 32'h0);
		p = reloads[1];
		s = stops[1];
		wr(`TCJS_REG_CTRL, 32'h3);
		wait_rl(1, p, 50);
		chk("no stop", s, stops[1]);
		chk("frame", exp_frame(32'hb), {10'h0, rx_frame[1]});
		$display("test payload done");
	endtask
	task automatic t_disc;
		tcjs_disc_t ev [4];
		ev = '{6'h20, 6'h08, 6'h02, 6'h01};
		output_frame_format[1] <= TCJS_FMT_25;
		foreach (ev[i]) begin
			p = reloads[1];
			disc(ev[i]);
			wait_rl(1, p, 50);
		end
		chk("frame 25", (32'he8b * `TCJS_FPS_25 + 32'h74) % (`TCJS_SECS_PER_DAY * `TCJS_FPS_25),
			{10'h0, rx_frame[1]});
		repeat (300) @(posedge clk);
		p = reloads[0];
		s = stops[0];
		disc(6'h10);
		wait_rl(0, p, 400);
		chk("stopped", s + 1, stops[0]);
		$display("test discontinuity done");
	endtask
	task automatic t_cf;
		wr(`TCJS_REG_CTRL, 32'h8);
		p = reloads[0];
		wr(`TCJS_REG_CTRL, 32'ha);
		idle(0, p);
		chk("held", 32'h0, {31'h0, ltc_out[0].run});
		rd("busy status", `TCJS_REG_STATUS, 32'h00020006);
		cf_sync <= 2'h1;
		@(posedge clk);
		cf_sync <= 2'h0;
		wait_rl(0, p, 20);
		$display("test colour frame done");
	endtask
	task automatic t_sched;
		wr(`TCJS_REG_START_TIME, 32'h00010204);
		wr(`TCJS_REG_START_DATE, 32'h07e8030f);
		wr(`TCJS_REG_INTERVAL, 32'h0);
		p = reloads[0];
		wr(`TCJS_REG_CTRL, 32'h4);
		idle(0, p);
		rd("armed status", `TCJS_REG_STATUS, 32'h00020013);
		wr(`TCJS_REG_CTRL, 32'h6);
		idle(0, p);
		tb_now.tod.ss <= 6'h4;
		tb_sec_tick <= 1'b1;
		@(posedge clk);
		tb_sec_tick <= 1'b0;
		wait_rl(0, p, 400);
		rd("repeat status", `TCJS_REG_STATUS, 32'h00030023);
		for (int i = 1; i < 4; i++) begin
			if (i == 3) begin
				wr(`TCJS_REG_CTRL, 32'h0);
			end
			@(posedge clk);
			tb_sec_tick <= 1'b1;
			@(posedge clk);
			tb_sec_tick <= 1'b0;
			if (i < 3) begin
				wait_rl(0, p + i, 400);
			end else begin
				idle(0, p + 3);
			end
		end
		$display("test schedule done");
	endtask
	task automatic final_report;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		$display("watchdog expired");
		final_report;
	end
	initial begin
		errors = 0;
		comparisons = 0;
		rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 3'h0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		tb_now = '{'{16'h07e8, 4'h3, 5'h0f}, '{5'h1, 6'h2, 6'h3}};
		tb_frame = 5'h5;
		tb_sec_tick = 1'b0;
		output_frame_format = '{TCJS_FMT_NT_NDROP, TCJS_FMT_NT_NDROP};
		phase_ofs_frames = '{22'hb, 22'h7};
		tz_ofs_frames = 22'h64;
		frame_tick = 2'h0;
		cf_sync = 2'h0;
		disc_event = '0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_restart;
		t_payload;
		t_disc;
		t_cf;
		t_sched;
		final_report;
	end
endmodule
